// ---- core/orfc_defs.vh ----
// Constants for the over-range flag and clock-out block.
// Assumes inclusion by bare name from core/ design files.
`ifndef ORFC_DEFS_VH
`define ORFC_DEFS_VH
`define ORFC_SAMPLE_W     9
`define ORFC_NPULSE_W     4
`define ORFC_CLKSEL_OFF   2'h0
`define ORFC_CLKSEL_COPY  2'h1
`define ORFC_CLKSEL_DIV2  2'h2
`define ORFC_CLKSEL_DIV4  2'h3
`define ORFC_VAR_SINGLE   2'h0
`define ORFC_VAR_DUAL     2'h1
`define ORFC_VAR_QUAD     2'h2
`endif

// ---- core/orfc_flag.v ----
// One channel's over-range detector with minimum pulse stretch.
// Assumes samples are synchronous to mclk; threshold and length static.
`include "orfc_defs.vh"
module orfc_flag (
    input  wire                          mclk,
    input  wire                          reset,
    input  wire                          enable,
    input  wire [`ORFC_SAMPLE_W-1:0]     sample_mag,
    input  wire [`ORFC_SAMPLE_W-1:0]     overrange_threshold,
    input  wire [`ORFC_NPULSE_W-1:0]     min_pulse_setting,
    output reg                           flag
);
    reg [`ORFC_NPULSE_W:0] hold_count;
    wire                   over = enable && (sample_mag > overrange_threshold);

    // Flag rises on over-range, held at least the programmed length
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            flag       <= 1'b0;
            hold_count <= {(`ORFC_NPULSE_W+1){1'b0}};
        end else if (over) begin
            flag       <= 1'b1;
            hold_count <= {1'b0, min_pulse_setting};
        end else if (hold_count != {(`ORFC_NPULSE_W+1){1'b0}}) begin
            hold_count <= hold_count - 1'b1;
        end else begin
            flag <= 1'b0;
        end
    end
endmodule

// ---- core/orfc_top.v ----
// Fast over-range flags for channels A-C; channel-C pin may carry a clock.
// Assumes sample magnitudes on mclk; ref clock is sampled as a pin input,
// so its frequency must stay well below half of mclk.
// Variant, threshold and select inputs are static levels on mclk.
`include "orfc_defs.vh"
// Functional notes
// - Flag high when magnitude exceeds threshold
// - Flag held for minimum pulse length
// - Channel B flag unused on single variant
// - Channel C detection only on quad
// - C pin clocks when selected and PLL on
// - Effective select zero gives flag; clock select without PLL gives low
// - Select 1 copy, 2 half, 3 quarter
// - Clock starts after the two-stage pin sync following reset release when enabled
// - Repeat output follows selected reference input when PLL on
// - Power-down stops repeat and C clock
module orfc_top (
    input  wire                          mclk,
    input  wire                          reset,
    input  wire [1:0]                    device_variant,
    input  wire [`ORFC_SAMPLE_W-1:0]     sample_mag_a,
    input  wire [`ORFC_SAMPLE_W-1:0]     sample_mag_b,
    input  wire [`ORFC_SAMPLE_W-1:0]     sample_mag_c,
    input  wire [`ORFC_SAMPLE_W-1:0]     overrange_threshold,
    input  wire [`ORFC_NPULSE_W-1:0]     min_pulse_setting,
    input  wire [1:0]                    clock_output_select,
    input  wire                          clock_override_en,
    input  wire [1:0]                    clock_override_select,
    input  wire                          pll_enable_pin,
    input  wire                          power_down_pin,
    input  wire                          ref_select_single_ended,
    input  wire                          ref_clock_diff,
    input  wire                          ref_clock_se,
    output reg                           over_range_flag_a,
    output reg                           over_range_flag_b,
    output reg                           over_range_flag_c_or_clock,
    output reg                           ref_clock_repeat_out
);
    // Bit positions of the asynchronous pins within the sync chain
    localparam integer PIN_COUNT  = 5;
    localparam integer PIN_PLL_EN = 4;
    localparam integer PIN_PD     = 3;
    localparam integer PIN_SEL_SE = 2;
    localparam integer PIN_REF_D  = 1;
    localparam integer PIN_REF_SE = 0;

    // Channel order within the per-channel vectors
    localparam integer CH_COUNT = 3;
    localparam integer CH_A     = 0;
    localparam integer CH_B     = 1;
    localparam integer CH_C     = 2;

    // Raw pin vector; only the first sync stage may read it
    wire [PIN_COUNT-1:0] pin_raw;
    assign pin_raw[PIN_PLL_EN] = pll_enable_pin;
    assign pin_raw[PIN_PD]     = power_down_pin;
    assign pin_raw[PIN_SEL_SE] = ref_select_single_ended;
    assign pin_raw[PIN_REF_D]  = ref_clock_diff;
    assign pin_raw[PIN_REF_SE] = ref_clock_se;

    // Two-stage synchronisers; metastability settles in stage one
    reg  [PIN_COUNT-1:0] sync1;
    reg  [PIN_COUNT-1:0] sync2;
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
        end
    end

    // Synchronised pin levels; everything downstream reads these
    wire pll_on;
    wire pd_on;
    wire sel_se;
    wire ref_diff;
    wire ref_se;
    assign pll_on   = sync2[PIN_PLL_EN];
    assign pd_on    = sync2[PIN_PD];
    assign sel_se   = sync2[PIN_SEL_SE];
    assign ref_diff = sync2[PIN_REF_D];
    assign ref_se   = sync2[PIN_REF_SE];

    // Per-channel enables by variant; A is present on every variant
    wire en_a;
    wire en_b;
    wire en_c;
    assign en_a = 1'b1;
    assign en_b = (device_variant != `ORFC_VAR_SINGLE);
    assign en_c = (device_variant == `ORFC_VAR_QUAD);

    // Channel inputs packed so one loop builds all detectors
    wire [CH_COUNT-1:0]                enable_vec;
    wire [CH_COUNT*`ORFC_SAMPLE_W-1:0] sample_vec;
    wire [CH_COUNT-1:0]                flag_vec;
    assign enable_vec = {en_c, en_b, en_a};
    assign sample_vec = {sample_mag_c, sample_mag_b, sample_mag_a};

    // One detector per channel; a disabled one never raises its flag
    genvar gc;
    generate
        for (gc = 0; gc < CH_COUNT; gc = gc + 1) begin : g_chan
            orfc_flag u_flag (
                .mclk                (mclk),
                .reset               (reset),
                .enable              (enable_vec[gc]),
                .sample_mag          (sample_vec[gc*`ORFC_SAMPLE_W +: `ORFC_SAMPLE_W]),
                .overrange_threshold (overrange_threshold),
                .min_pulse_setting   (min_pulse_setting),
                .flag                (flag_vec[gc])
            );
        end
    endgenerate

    // Detector results by channel name
    wire flag_a;
    wire flag_b;
    wire flag_c;
    assign flag_a = flag_vec[CH_A];
    assign flag_b = flag_vec[CH_B];
    assign flag_c = flag_vec[CH_C];

    // Selected reference; both inputs are sampled, never used as clocks
    wire ref_sel;
    assign ref_sel = sel_se ? ref_se : ref_diff;

    // Override pair replaces the strap select when enabled
    wire [1:0] eff_sel;
    assign eff_sel = clock_override_en ? clock_override_select : clock_output_select;

    // Clock gating; power-down wins over the PLL enable
    wire sel_is_clock;
    wire clk_allowed;
    wire clk_mode;
    assign sel_is_clock = (eff_sel != `ORFC_CLKSEL_OFF);
    assign clk_allowed  = pll_on && !pd_on;
    assign clk_mode     = sel_is_clock && clk_allowed;

    // Rising edge of the sampled reference; prev resets to idle level
    reg  ref_prev;
    wire ref_rise;
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            ref_prev <= 1'b0;
        end else begin
            ref_prev <= ref_sel;
        end
    end
    assign ref_rise = ref_sel && !ref_prev;

    // Divider counts reference rises; bit 0 halves, bit 1 quarters
    reg [1:0] div_count;
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            div_count <= 2'h0;
        end else if (ref_rise) begin
            div_count <= div_count + 2'h1;
        end
    end

    // Clock choice for the channel-C pin; divided copies keep even duty
    reg clk_c;
    always @* begin
        case (eff_sel)
            `ORFC_CLKSEL_COPY: clk_c = ref_sel;
            `ORFC_CLKSEL_DIV2: clk_c = div_count[0];
            `ORFC_CLKSEL_DIV4: clk_c = div_count[1];
            default:           clk_c = 1'b0;
        endcase
    end

    // Next value of the channel-C pin: clock, flag or held low
    reg next_pin_c;
    always @* begin
        if (clk_mode) begin
            next_pin_c = clk_c;
        end else if (!sel_is_clock) begin
            next_pin_c = flag_c;
        end else begin
            next_pin_c = 1'b0;
        end
    end

    // Repeat output gated by PLL enable and power-down only, not by the select
    wire next_repeat;
    assign next_repeat = clk_allowed && ref_sel;

    // Flag outputs registered so the pins come straight from flops
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            over_range_flag_a <= 1'b0;
            over_range_flag_b <= 1'b0;
        end else begin
            over_range_flag_a <= flag_a;
            over_range_flag_b <= flag_b;
        end
    end

    // Channel-C pin; clock mode waits for the two-stage pin sync after reset release
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            over_range_flag_c_or_clock <= 1'b0;
        end else begin
            over_range_flag_c_or_clock <= next_pin_c;
        end
    end

    // Repeat pin; parked low while stopped, gating not aligned to reference edges
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            ref_clock_repeat_out <= 1'b0;
        end else begin
            ref_clock_repeat_out <= next_repeat;
        end
    end
endmodule

// ---- verif/orfc_chk.sv ----
// Checker: port-level assertions for the over-range and clock block.
// Assumes bind into orfc_top; threshold and pulse length held static.
`include "orfc_defs.vh"
module orfc_chk (
    input wire logic mclk, reset, pll_enable_pin, power_down_pin,
    input wire logic clock_override_en, ref_select_single_ended,
    input wire logic ref_clock_diff, ref_clock_se, ref_clock_repeat_out,
    input wire logic over_range_flag_a, over_range_flag_b, over_range_flag_c_or_clock,
    input wire logic [1:0] device_variant, clock_output_select, clock_override_select,
    input wire logic [`ORFC_SAMPLE_W-1:0] sample_mag_a, overrange_threshold,
    input wire logic [`ORFC_NPULSE_W-1:0] min_pulse_setting
);
    timeunit 1ns;
    timeprecision 100ps;
    // Effective mode; override pair replaces the strap select
    wire [1:0] sel = clock_override_en ? clock_override_select : clock_output_select;
    wire on = pll_enable_pin && !power_down_pin;
    wire ov = sample_mag_a > overrange_threshold;
    wire rs = ref_select_single_ended ? ref_clock_se : ref_clock_diff;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // Six cycles covers the two-stage pin sync plus output register
    sequence live_on;
        (on && $stable(ref_select_single_ended))[*6];
    endsequence
    flag_rise_a: assert property (ov |-> ##[1:2] over_range_flag_a) else $error("a late");
    flag_hold_a: assert property (
        $rose(over_range_flag_a) && min_pulse_setting == 4'h3 |-> over_range_flag_a[*4])
        else $error("a short");
    flag_drop_a: assert property (
        $fell(over_range_flag_a) |-> !$past(ov) && !$past(ov, 2))
        else $error("a early");
    flag_b_off_a: assert property (
        (device_variant == 2'h0)[*8] |-> !over_range_flag_b)
        else $error("b on");
    c_quad_only_a: assert property (
        (device_variant != 2'h2 && sel == 2'h0)[*8] |-> !over_range_flag_c_or_clock)
        else $error("c on");
    pll_gate_a: assert property (
        (!pll_enable_pin && sel != 2'h0)[*4] |-> !over_range_flag_c_or_clock)
        else $error("c no pll");
    pd_stop_a: assert property (
        (power_down_pin && sel != 2'h0)[*4]
        |-> !over_range_flag_c_or_clock && !ref_clock_repeat_out) else $error("pd");
    repeat_follow_a: assert property (
        live_on |-> ref_clock_repeat_out == $past(rs, 3))
        else $error("repeat");
endmodule
bind orfc_top orfc_chk u_chk (.*);

// ---- verif/orfc_refgen.sv ----
// Partner: free-running reference oscillators feeding the clock pins.
// Assumes the bench wires both outputs to the block's ref inputs.
module orfc_refgen (
    output logic ref_clock_diff,
    output logic ref_clock_se
);
    timeunit 1ns;
    timeprecision 100ps;
    // Distinct rates so the bench can tell which input is repeated
    initial begin
        ref_clock_diff = 1'b0;
        ref_clock_se = 1'b0;
    end
    always #100 ref_clock_diff = ~ref_clock_diff;
    always #160 ref_clock_se = ~ref_clock_se;
endmodule

// ---- verif/tb.sv ----
// Bench: flag stretch, variants and clock-out modes of orfc_top.
// Assumes the partner oscillators and the bound checker are compiled.
`include "orfc_defs.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0, reset = 1'b1, clock_override_en = 1'b0, pll_enable_pin = 1'b1;
    logic power_down_pin = 1'b0, ref_select_single_ended = 1'b0;
    logic [1:0] device_variant = 2'h2, clock_output_select = 2'h1, clock_override_select = 2'h0;
    logic [`ORFC_SAMPLE_W-1:0] sample_mag_a = 9'h000, sample_mag_b = 9'h000;
    logic [`ORFC_SAMPLE_W-1:0] sample_mag_c = 9'h000, overrange_threshold = 9'h064;
    logic [`ORFC_NPULSE_W-1:0] min_pulse_setting = 4'h3;
    logic ref_clock_diff, ref_clock_se, over_range_flag_a, over_range_flag_b;
    logic over_range_flag_c_or_clock, ref_clock_repeat_out;
    int n_fail = 0, num_checks = 0;
    // Four-state counters so an unknown output cannot pass as zero
    integer na, nb, nc, nr;
    orfc_top u_orfc_top (.*);
    orfc_refgen u_orfc_refgen (.*);
    always #12.5 mclk = ~mclk;
    // High cycles of flags a/b, rises of pin c and repeat output
    task automatic run(input int cyc);
        logic pc, pr;
        {na, nb, nc, nr} = '0;
        pc = over_range_flag_c_or_clock;
        pr = ref_clock_repeat_out;
        repeat (cyc) begin
            @(negedge mclk);
            na += over_range_flag_a;
            nb += over_range_flag_b;
            nc += over_range_flag_c_or_clock & !pc;
            nr += ref_clock_repeat_out & !pr;
            pc = over_range_flag_c_or_clock;
            pr = ref_clock_repeat_out;
        end
    endtask
    // One over cycle, then samples equal to threshold must not extend
    task automatic t_flags(input logic [1:0] v, input int eb, input int ec);
        device_variant = v;
        {sample_mag_a, sample_mag_b, sample_mag_c} = {3{9'h065}};
        @(negedge mclk);
        {sample_mag_a, sample_mag_b, sample_mag_c} = {3{9'h064}};
        run(16);
        `CHK(na, 4)
        `CHK(nb, eb)
        `CHK(nc, ec)
    endtask
    // Rise count over 640 cycles; edge slip allows one either way
    task automatic t_clk(input logic [1:0] s, input logic o, input logic p, input int ec);
        clock_output_select = o ? ~s : s;
        clock_override_select = s;
        clock_override_en = o;
        pll_enable_pin = p;
        run(8);
        run(640);
        `CHK(nc >= ec - 1 && nc <= ec + 1, 1'b1)
    endtask
    task automatic tally_and_finish;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Main sequence; inputs change on falling edges only
    initial begin
        repeat (16) @(negedge mclk);
        reset = 1'b0;
        run(80);
        `CHK(nc > 0, 1'b1)
        t_clk(2'h1, 1'b0, 1'b1, 80);
        `CHK(nr >= 79 && nr <= 81, 1'b1)
        t_clk(2'h2, 1'b0, 1'b1, 40);
        t_clk(2'h3, 1'b0, 1'b1, 20);
        t_clk(2'h3, 1'b0, 1'b0, 0);
        t_clk(2'h2, 1'b1, 1'b1, 40);
        t_clk(2'h0, 1'b1, 1'b1, 0);
        power_down_pin = 1'b1;
        t_clk(2'h1, 1'b0, 1'b1, 0);
        `CHK(nr, 0)
        power_down_pin = 1'b0;
        ref_select_single_ended = 1'b1;
        t_clk(2'h0, 1'b0, 1'b1, 0);
        `CHK(nr >= 49 && nr <= 51, 1'b1)
        t_flags(2'h2, 4, 1);
        t_flags(2'h1, 4, 0);
        t_flags(2'h0, 0, 0);
        tally_and_finish;
    end
    // Hang guard well past the expected run length
    initial begin
        #400us;
        n_fail++;
        tally_and_finish;
    end
endmodule
